// ### bench/tb_top.sv
// Self-checking bench for the tuner configuration bank.
// Assumes the checker is bound to the bank; short counts keep the autoselect run brief.
`timescale 1ns/10ps
module tb_top;
  import tuner_cfg_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic reference_divide_pin_open_i = 0, reference_divide_pin_i = 0;
  logic [7:0] adr_i = 0;
  logic [3:0] sel_i = 0;
  logic [31:0] dat_i = 0, dat_o, q;
  logic [2:0] tune_adc_code_i = 0, wideband_attack_point_o, narrowband_attack_point_o;
  logic [1:0] agc_diode_voltage_o;
  logic ack_o, reference_clock_output_o, rf_enable_o, mixer_enable_o, if_enable_o, if_gain_amp_enable_o;
  logic detector_enable_o, synth_enable_o, oscillator_enable_o, autoselect_running_o, autoselect_from_current_o;
  logic wideband_detector_enable_o, narrowband_detector_enable_o, agc_diode_enable_o;
  logic [6:0] en;
  logic [2:0] det;
  int bad_count = 0, compares = 0, clocks = 0, n;
  logic [5:0] ixs [6] = '{IDX_FRAC_LOW, IDX_SHUTDOWN, IDX_REF_CFG, IDX_VAS_CFG, IDX_PD_CFG_A, IDX_PD_CFG_B};
  logic [7:0] rvs [6] = '{8'h66, 8'h00, 8'h0a, 8'h12, 8'h43, 8'h01};
  assign en = {rf_enable_o, mixer_enable_o, if_enable_o, if_gain_amp_enable_o, detector_enable_o, synth_enable_o,
    oscillator_enable_o};
  assign det = {wideband_detector_enable_o, narrowband_detector_enable_o, agc_diode_enable_o};
  always #5 clk_i = ~clk_i;
  tuner_cfg_regs #(.LF_BASE_RATIO(1), .WAIT_UNIT_TICKS(4)) i_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .reference_divide_pin_open_i, .reference_divide_pin_i, .tune_adc_code_i,
    .reference_clock_output_o, .rf_enable_o, .mixer_enable_o, .if_enable_o, .if_gain_amp_enable_o,
    .detector_enable_o, .synth_enable_o, .oscillator_enable_o, .autoselect_running_o, .autoselect_from_current_o,
    .wideband_detector_enable_o, .wideband_attack_point_o, .narrowband_detector_enable_o,
    .narrowband_attack_point_o, .agc_diode_voltage_o, .agc_diode_enable_o);
  task conclude;
    if (bad_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Called just after a rising edge; leaves one idle cycle before returning.
  task bus(input logic w, input logic [5:0] ix, input logic [7:0] d, input logic [3:0] s);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= {ix, 2'h0};
    dat_i <= {24'h0, d};
    sel_i <= s;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
    @(posedge clk_i);
  endtask
  task wr(input logic [5:0] ix, input logic [7:0] d);
    bus(1, ix, d, 4'hf);
  endtask
  task rd(input logic [5:0] ix);
    bus(0, ix, 8'h0, 4'hf);
  endtask
  task ticks;
    repeat (8) @(posedge clk_i);
    n = 0;
    repeat (8)
    begin
      @(posedge clk_i);
      n += (reference_clock_output_o === 1'b1);
    end
  endtask
  always @(posedge clk_i)
  begin
    clocks++;
    if (clocks == 20000)
    begin
      bad_count++;
      conclude();
    end
  end
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    for (int i = 0; i < 6; i++)
    begin
      rd(ixs[i]);
      chk("reset value", q, {24'h0, rvs[i]});
    end
    chk("enables", en, 7'h7f);
    chk("detectors", {det, wideband_attack_point_o, narrowband_attack_point_o}, 9'h1e3);
    wr(IDX_REF_CFG, 8'hff);
    rd(IDX_REF_CFG);
    chk("ref cfg", q, 32'h1f);
    wr(IDX_PD_CFG_B, 8'hff);
    rd(IDX_PD_CFG_B);
    chk("detector b", q, 32'h07);
    bus(1, IDX_SHUTDOWN, 8'hff, 4'h0);
    rd(IDX_SHUTDOWN);
    chk("unselected write", q, 32'h0);
    wr(6'h3f, 8'h5a);
    rd(6'h3f);
    chk("unmapped", q, 32'h0);
    wr(IDX_REF_CFG, 8'h0a);
    for (int i = 0; i < 7; i++)
    begin
      wr(IDX_SHUTDOWN, 8'h1 << i);
      chk("enables", en, 7'h7f & ~(7'h1 << i));
    end
    wr(IDX_SHUTDOWN, 8'h80);
    chk("standby enables", {en, det}, 10'h0);
    ticks();
    chk("standby reference", n, 2);
    wr(IDX_SHUTDOWN, 8'h00);
    reference_divide_pin_open_i <= 1;
    wr(IDX_REF_CFG, 8'h0b);
    ticks();
    chk("reference undivided", n, 8);
    wr(IDX_REF_CFG, 8'h0a);
    ticks();
    chk("reference divided", n, 2);
    reference_divide_pin_open_i <= 0;
    reference_divide_pin_i <= 1;
    ticks();
    chk("pin undivided", n, 8);
    reference_divide_pin_i <= 0;
    wr(IDX_VAS_CFG, 8'h32);
    chk("start select", autoselect_from_current_o, 1);
    wr(IDX_VAS_CFG, 8'h12);
    chk("start select", autoselect_from_current_o, 0);
    tune_adc_code_i <= 3'h5;
    wr(IDX_VAS_CFG, 8'h0c);
    rd(IDX_GEN_STATUS);
    chk("adc read", q, 32'h5);
    wr(IDX_VAS_CFG, 8'h04);
    tune_adc_code_i <= 3'h2;
    rd(IDX_GEN_STATUS);
    chk("adc held", q, 32'h5);
    wr(IDX_VAS_CFG, 8'h08);
    rd(IDX_GEN_STATUS);
    chk("adc read off", q, 32'h0);
    wr(IDX_PD_CFG_A, 8'h88);
    chk("detectors off", det[2:1], 2'h0);
    wr(IDX_PD_CFG_A, 8'h70);
    chk("attack", {det[2:1], wideband_attack_point_o, narrowband_attack_point_o}, 8'hf8);
    wr(IDX_PD_CFG_A, 8'h43);
    for (int c = 0; c < 4; c++)
    begin
      wr(IDX_PD_CFG_B, c[7:0]);
      chk("diode", {det[0], agc_diode_voltage_o}, {c != 3, c[1:0]});
    end
    wr(IDX_VAS_CFG, 8'h12);
    rd(IDX_VAS_STATUS);
    chk("idle flag", q, 32'h1);
    wr(IDX_FRAC_LOW, 8'h5a);
    chk("running", autoselect_running_o, 1);
    rd(IDX_VAS_STATUS);
    chk("busy flag", q, 32'h0);
    for (int i = 0; i < 200 && autoselect_running_o !== 1'b0; i++)
      @(posedge clk_i);
    rd(IDX_VAS_STATUS);
    chk("idle again", q, 32'h1);
    rd(IDX_FRAC_LOW);
    chk("fraction low", q, 32'h5a);
    conclude();
  end
endmodule // tb_top

// ### bench/tuner_cfg_assertions.sv
// Concurrent checks on the ports of the tuner configuration bank.
// Assumes one clock domain, synchronous reset and a bench that speaks classic Wishbone.
`timescale 1ns/10ps
module tuner_cfg_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic reference_divide_pin_open_i,
  input wire logic reference_divide_pin_i,
  input wire logic reference_clock_output_o,
  input wire logic autoselect_running_o,
  input wire logic [1:0] agc_diode_voltage_o,
  input wire logic agc_diode_enable_o
);
  import tuner_cfg_pkg::*;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic div1;
  logic div4;
  logic tk;
  assign div1 = !reference_divide_pin_open_i && reference_divide_pin_i;
  assign div4 = !reference_divide_pin_open_i && !reference_divide_pin_i;
  assign tk = reference_clock_output_o;
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_steady4;
    div4 [*8] ##0 tk;
  endsequence
  property p_ack_resp;
    s_req |=> ack_o;
  endproperty
  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  property p_ack_cause;
    ack_o |-> $past(cyc_i && stb_i);
  endproperty
  property p_dat_hi;
    ack_o |-> dat_o[31:8] == 24'h0;
  endproperty
  property p_dat_hold;
    !ack_o |-> $stable(dat_o);
  endproperty
  property p_div1;
    div1 [*8] |-> tk;
  endproperty
  property p_div4_period;
    s_steady4 |-> $past(tk, 4);
  endproperty
  property p_div4_gap;
    s_steady4 ##1 div4 [*3] |-> !tk && !$past(tk) && !$past(tk, 2);
  endproperty
  property p_run_start;
    $rose(autoselect_running_o) |-> $past(ack_o && we_i && adr_i[7:2] == IDX_FRAC_LOW);
  endproperty
  property p_diode;
    agc_diode_enable_o |-> agc_diode_voltage_o != DIODE_OFF_CODE;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("request not answered");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  a_dat_hi: assert property (p_dat_hi) else $error("upper read bits not zero");
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved without ack");
  a_div1: assert property (p_div1) else $error("undivided reference missing a tick");
  a_div4_period: assert property (p_div4_period) else $error("divided reference period wrong");
  a_div4_gap: assert property (p_div4_gap) else $error("divided reference ticks too close");
  a_run_start: assert property (p_run_start) else $error("autoselect started without trigger");
  a_diode: assert property (p_diode) else $error("diode on with off code");
endmodule // tuner_cfg_checker
bind tuner_cfg_regs tuner_cfg_checker i_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o, .ack_o,
  .reference_divide_pin_open_i, .reference_divide_pin_i, .reference_clock_output_o, .autoselect_running_o,
  .agc_diode_voltage_o, .agc_diode_enable_o);

// ### hdl/tick_divider.sv
// Divides the system clock into a one-cycle enable pulse.
// Assumes a synchronous active-high reset; a ratio of one gives a pulse every cycle.
`timescale 1ns/10ps
module tick_divider #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] ratio_i,
  output logic tick_o
);
  logic [W-1:0] count_q;
  logic last;

  if (W < 1)
  begin : g_chk
    $error("tick_divider width must be at least one");
  end

  // A ratio of zero is treated as one so the pulse never stops.
  assign last = (count_q + W'(1) >= ratio_i);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count_q <= '0;
      tick_o <= 1'b0;
    end
    else
    begin
      count_q <= last ? '0 : count_q + W'(1);
      tick_o <= last;
    end
  end
endmodule // tick_divider

// ### hdl/tuner_cfg_pkg.sv
// Constants for the tuner power, reference, autoselect and detector register bank.
// Assumes a 32-bit classic Wishbone slave with one register per aligned word.
package tuner_cfg_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [5:0] IDX_FRAC_LOW = 6'h04;
  localparam logic [5:0] IDX_SHUTDOWN = 6'h08;
  localparam logic [5:0] IDX_REF_CFG = 6'h09;
  localparam logic [5:0] IDX_VAS_CFG = 6'h0a;
  localparam logic [5:0] IDX_PD_CFG_A = 6'h0b;
  localparam logic [5:0] IDX_PD_CFG_B = 6'h0c;
  localparam logic [5:0] IDX_VAS_STATUS = 6'h11;
  localparam logic [5:0] IDX_GEN_STATUS = 6'h12;

  // Reset values (the nominal settings).
  localparam logic [7:0] RST_FRAC_LOW = 8'h66;
  localparam logic [7:0] RST_SHUTDOWN = 8'h00;
  localparam logic [7:0] RST_REF_CFG = 8'h0a;
  localparam logic [7:0] RST_VAS_CFG = 8'h12;
  localparam logic [7:0] RST_PD_CFG_A = 8'h43;
  localparam logic [7:0] RST_PD_CFG_B = 8'h01;

  // Writable bit masks; other bits are empty and read as zero.
  localparam logic [7:0] MASK_REF_CFG = 8'h1f;
  localparam logic [7:0] MASK_PD_CFG_B = 8'h07;

  // Shutdown register fields.
  localparam int SD_STANDBY = 7;
  localparam int SD_RF = 6;
  localparam int SD_MIXER = 5;
  localparam int SD_IF = 4;
  localparam int SD_IF_VGA = 3;
  localparam int SD_DETECTOR = 2;
  localparam int SD_SYNTH = 1;
  localparam int SD_OSC = 0;

  // Reference and autoselect configuration fields.
  localparam int REF_DIV_SEL = 0;
  localparam int VAS_LFDIV_HI = 7;
  localparam int VAS_LFDIV_LO = 6;
  localparam int VAS_START_SEL = 5;
  localparam int VAS_ENABLE = 4;
  localparam int VAS_ADC_LATCH = 3;
  localparam int VAS_ADC_READ = 2;
  localparam int VAS_WAIT_HI = 1;
  localparam int VAS_WAIT_LO = 0;

  // Power detector fields.
  localparam int PDA_WB_OFF = 7;
  localparam int PDA_WB_HI = 6;
  localparam int PDA_WB_LO = 4;
  localparam int PDA_NB_OFF = 3;
  localparam int PDA_NB_HI = 2;
  localparam int PDA_NB_LO = 0;
  localparam int PDB_DIODE_HI = 1;
  localparam int PDB_DIODE_LO = 0;
  localparam logic [1:0] DIODE_OFF_CODE = 2'h3;

  // Reference output division ratios.
  localparam logic [2:0] REF_RATIO_DIV4 = 3'h4;
  localparam logic [2:0] REF_RATIO_DIV1 = 3'h1;

  // Status fields.
  localparam int VST_IDLE = 0;
  localparam int GST_ADC_HI = 2;
  localparam int GST_ADC_LO = 0;
endpackage

// ### hdl/tuner_cfg_regs.sv
// Power, reference, VCO autoselect and power-detector control registers of the tuner.
// Assumes a classic Wishbone master on clk_i and a free-running crystal-rate clk_i.
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/10ps
module tuner_cfg_regs #(
  parameter int LF_BASE_RATIO = 16,
  parameter int WAIT_UNIT_TICKS = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic reference_divide_pin_open_i,
  input wire logic reference_divide_pin_i,
  input wire logic [2:0] tune_adc_code_i,
  output logic reference_clock_output_o,
  output logic rf_enable_o,
  output logic mixer_enable_o,
  output logic if_enable_o,
  output logic if_gain_amp_enable_o,
  output logic detector_enable_o,
  output logic synth_enable_o,
  output logic oscillator_enable_o,
  output logic autoselect_running_o,
  output logic autoselect_from_current_o,
  output logic wideband_detector_enable_o,
  output logic [2:0] wideband_attack_point_o,
  output logic narrowband_detector_enable_o,
  output logic [2:0] narrowband_attack_point_o,
  output logic [1:0] agc_diode_voltage_o,
  output logic agc_diode_enable_o
);
  import tuner_cfg_pkg::*;

  typedef enum logic [1:0] {
    VAS_IDLE,
    VAS_WAIT,
    VAS_SEARCH
  } vas_state_t;

  // The low-frequency divider is nine bits wide, so the base ratio shifted by three must stay below 512.
  if (LF_BASE_RATIO < 1 || LF_BASE_RATIO > 63)
  begin : g_chk_lf
    $error("LF_BASE_RATIO must lie between 1 and 63");
  end
  if (WAIT_UNIT_TICKS < 1 || WAIT_UNIT_TICKS > 1024)
  begin : g_chk_wait
    $error("WAIT_UNIT_TICKS must lie between 1 and 1024");
  end

  logic [7:0] frac_low_q;
  logic [7:0] shutdown_q;
  logic [7:0] ref_cfg_q;
  logic [7:0] vas_cfg_q;
  logic [7:0] pd_cfg_a_q;
  logic [7:0] pd_cfg_b_q;
  logic [2:0] adc_latched_q;
  vas_state_t vas_state_q;
  logic [12:0] wait_count_q;
  logic ref_tick;
  logic lf_tick;
  logic [2:0] ref_ratio;
  logic [8:0] lf_ratio;
  logic req;
  logic wr_byte;
  logic [5:0] idx;
  logic [7:0] rd_byte;
  logic vas_idle;
  logic [12:0] wait_target;

  assign req = cyc_i & stb_i & ~ack_o;
  assign wr_byte = req & we_i & sel_i[0];
  assign idx = adr_i[7:2];
  assign vas_idle = (vas_state_q == VAS_IDLE);

  // The pin, when driven, overrides the register select; high means undivided.
  always_comb
  begin
    if (reference_divide_pin_open_i)
    begin
      ref_ratio = ref_cfg_q[REF_DIV_SEL] ? REF_RATIO_DIV1 : REF_RATIO_DIV4;
    end
    else
    begin
      ref_ratio = reference_divide_pin_i ? REF_RATIO_DIV1 : REF_RATIO_DIV4;
    end
  end

  // The low-frequency clock halves again with each step of the divider field.
  assign lf_ratio = 9'(LF_BASE_RATIO) << vas_cfg_q[VAS_LFDIV_HI:VAS_LFDIV_LO];

  // Settle time grows with the wait-time code so a longer code waits longer.
  assign wait_target = 13'(WAIT_UNIT_TICKS) * 13'({1'b0, vas_cfg_q[VAS_WAIT_HI:VAS_WAIT_LO]} + 3'h1);

  tick_divider #(
    .W(3)
  ) u_ref_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ratio_i(ref_ratio),
    .tick_o(ref_tick)
  );

  tick_divider #(
    .W(9)
  ) u_lf_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ratio_i(lf_ratio),
    .tick_o(lf_tick)
  );

  // Register writes; empty bits are masked so they never store.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      frac_low_q <= RST_FRAC_LOW;
      shutdown_q <= RST_SHUTDOWN;
      ref_cfg_q <= RST_REF_CFG;
      vas_cfg_q <= RST_VAS_CFG;
      pd_cfg_a_q <= RST_PD_CFG_A;
      pd_cfg_b_q <= RST_PD_CFG_B;
    end
    else if (wr_byte)
    begin
      unique case (idx)
        IDX_FRAC_LOW: frac_low_q <= dat_i[7:0];
        IDX_SHUTDOWN: shutdown_q <= dat_i[7:0];
        IDX_REF_CFG: ref_cfg_q <= dat_i[7:0] & MASK_REF_CFG;
        IDX_VAS_CFG: vas_cfg_q <= dat_i[7:0];
        IDX_PD_CFG_A: pd_cfg_a_q <= dat_i[7:0];
        IDX_PD_CFG_B: pd_cfg_b_q <= dat_i[7:0] & MASK_PD_CFG_B;
        default: ;
      endcase
    end
  end

  // Autoselect sequencer: a settle wait, then one low-frequency period of search.
  // A fresh write of the low fraction restarts it, so the newest target wins.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      vas_state_q <= VAS_IDLE;
      wait_count_q <= '0;
    end
    else if (wr_byte && idx == IDX_FRAC_LOW && vas_cfg_q[VAS_ENABLE])
    begin
      vas_state_q <= VAS_WAIT;
      wait_count_q <= '0;
    end
    else if (!vas_cfg_q[VAS_ENABLE] || shutdown_q[SD_STANDBY])
    begin
      vas_state_q <= VAS_IDLE;
      wait_count_q <= '0;
    end
    else
    begin
      unique case (vas_state_q)
        VAS_IDLE: wait_count_q <= '0;
        VAS_WAIT:
        begin
          if (lf_tick)
          begin
            if (wait_count_q + 13'h1 >= wait_target)
            begin
              vas_state_q <= VAS_SEARCH;
              wait_count_q <= '0;
            end
            else
            begin
              wait_count_q <= wait_count_q + 13'h1;
            end
          end
        end
        VAS_SEARCH:
        begin
          if (lf_tick)
          begin
            vas_state_q <= VAS_IDLE;
          end
        end
      endcase
    end
  end

  // Manual tuning-voltage capture, only honoured with autoselect off.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      adc_latched_q <= '0;
    end
    else if (!vas_cfg_q[VAS_ENABLE] && vas_cfg_q[VAS_ADC_LATCH])
    begin
      adc_latched_q <= tune_adc_code_i;
    end
  end

  // Status reads are assembled here; the ADC code stays hidden while autoselect owns the converter.
  always_comb
  begin
    rd_byte = 8'h00;
    unique case (idx)
      IDX_FRAC_LOW: rd_byte = frac_low_q;
      IDX_SHUTDOWN: rd_byte = shutdown_q;
      IDX_REF_CFG: rd_byte = ref_cfg_q;
      IDX_VAS_CFG: rd_byte = vas_cfg_q;
      IDX_PD_CFG_A: rd_byte = pd_cfg_a_q;
      IDX_PD_CFG_B: rd_byte = pd_cfg_b_q;
      IDX_VAS_STATUS: rd_byte[VST_IDLE] = vas_idle;
      IDX_GEN_STATUS:
      begin
        if (!vas_cfg_q[VAS_ENABLE] && vas_cfg_q[VAS_ADC_READ])
        begin
          rd_byte[GST_ADC_HI:GST_ADC_LO] = adc_latched_q;
        end
      end
      default: rd_byte = 8'h00;
    endcase
  end

  // Single-wait-state slave: ack one cycle after the request, dropped the next.
  // Unmapped addresses still acknowledge and read zero so a master never hangs.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end
    else
    begin
      ack_o <= req;
      if (req && !we_i)
      begin
        dat_o <= {24'h000000, rd_byte};
      end
    end
  end

  // Analog block enables; standby clears every enable, oscillator included, and leaves only the reference output.
  // A shutdown write reaches these enables one edge after the register itself changes.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rf_enable_o <= 1'b0;
      mixer_enable_o <= 1'b0;
      if_enable_o <= 1'b0;
      if_gain_amp_enable_o <= 1'b0;
      detector_enable_o <= 1'b0;
      synth_enable_o <= 1'b0;
      oscillator_enable_o <= 1'b0;
    end
    else
    begin
      rf_enable_o <= ~shutdown_q[SD_STANDBY] & ~shutdown_q[SD_RF];
      mixer_enable_o <= ~shutdown_q[SD_STANDBY] & ~shutdown_q[SD_MIXER];
      if_enable_o <= ~shutdown_q[SD_STANDBY] & ~shutdown_q[SD_IF];
      if_gain_amp_enable_o <= ~shutdown_q[SD_STANDBY] & ~shutdown_q[SD_IF_VGA];
      detector_enable_o <= ~shutdown_q[SD_STANDBY] & ~shutdown_q[SD_DETECTOR];
      synth_enable_o <= ~shutdown_q[SD_STANDBY] & ~shutdown_q[SD_SYNTH];
      oscillator_enable_o <= ~shutdown_q[SD_STANDBY] & ~shutdown_q[SD_OSC];
    end
  end

  // Reference output keeps running in standby; it is a tick train at the divided rate.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      reference_clock_output_o <= 1'b0;
    end
    else
    begin
      reference_clock_output_o <= ref_tick;
    end
  end

  // The start select is only a level for the analog sequencer; the bank itself does not act on it.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      autoselect_running_o <= 1'b0;
      autoselect_from_current_o <= 1'b0;
    end
    else
    begin
      autoselect_running_o <= ~vas_idle;
      autoselect_from_current_o <= vas_cfg_q[VAS_START_SEL];
    end
  end

  // Detector and gain-control diode settings follow their fields; standby also clears the three enables.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wideband_detector_enable_o <= 1'b0;
      wideband_attack_point_o <= '0;
      narrowband_detector_enable_o <= 1'b0;
      narrowband_attack_point_o <= '0;
      agc_diode_voltage_o <= '0;
      agc_diode_enable_o <= 1'b0;
    end
    else
    begin
      wideband_detector_enable_o <= ~pd_cfg_a_q[PDA_WB_OFF] & ~shutdown_q[SD_STANDBY];
      wideband_attack_point_o <= pd_cfg_a_q[PDA_WB_HI:PDA_WB_LO];
      narrowband_detector_enable_o <= ~pd_cfg_a_q[PDA_NB_OFF] & ~shutdown_q[SD_STANDBY];
      narrowband_attack_point_o <= pd_cfg_a_q[PDA_NB_HI:PDA_NB_LO];
      agc_diode_voltage_o <= pd_cfg_b_q[PDB_DIODE_HI:PDB_DIODE_LO];
      agc_diode_enable_o <= (pd_cfg_b_q[PDB_DIODE_HI:PDB_DIODE_LO] != DIODE_OFF_CODE)
                            & ~shutdown_q[SD_STANDBY];
    end
  end
endmodule // tuner_cfg_regs
